// >>> rtl/cid_params.svh
/*
 holds the opcode patterns, field positions, reset values and modifier codes
 of the instruction decoder as macros; assumes nothing of its surroundings.
*/
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH

// word and field sizes
`define CID_INSN_W        14
`define CID_DATA_W        8
`define CID_PTR_W         16
`define CID_FILE_AW       7
`define CID_FILE_DEPTH    128

// full-word encodings
`define CID_OP_STANDBY    14'h0063
`define CID_OP_DIRMASK    14'h3FF8
`define CID_OP_DIRLOAD    14'h0060
`define CID_OP_IND_MASK   14'h3FF0
`define CID_OP_IND        14'h0010

// top-six-bit opcode groups
`define CID_TOP_PTRADD    6'h31
`define CID_TOP_IDX       6'h3F
`define CID_TOP_ANDLIT    6'h39
`define CID_TOP_ADDLIT    6'h3E
`define CID_TOP_ANDREG    6'h05
`define CID_TOP_ADDREG    6'h07

// field positions
`define CID_BIT_WRITE     7
`define CID_BIT_PTR_IDX   6
`define CID_BIT_PTR_IND   2
`define CID_BIT_DEST      7

// modifier codes of the indirect moves
`define CID_MM_PREINC     2'h0
`define CID_MM_PREDEC     2'h1
`define CID_MM_POSTINC    2'h2
`define CID_MM_POSTDEC    2'h3

// reset values
`define CID_ACC_RESET     8'h00
`define CID_PTR_RESET     16'h0000

`endif

// >>> rtl/cid_pkg.sv
/*
 holds the types of the instruction decoder; assumes cid_params.svh
 supplies the numeric constants.
*/
package cid_pkg;
   typedef enum logic [2:0] {
      CID_EXEC  = 3'b001,
      CID_IDLE  = 3'b010,
      CID_STALL = 3'b100
   } cid_state_t;
endpackage

// >>> rtl/cid_file_mem.sv
/*
 holds the 128-byte file register memory with a registered read port and
 one write port; assumes a single clock and synchronous use.
*/
`timescale 1ns/1ps
`include "cid_params.svh"

module cid_file_mem (
   // clock
   input  wire logic                      clk,
   // read port
   input  wire logic [`CID_FILE_AW-1:0]   rd_addr,
   output logic      [`CID_DATA_W-1:0]    rd_data,
   // write port
   input  wire logic                      wr_en,
   input  wire logic [`CID_FILE_AW-1:0]   wr_addr,
   input  wire logic [`CID_DATA_W-1:0]    wr_data
);
   logic [`CID_DATA_W-1:0] mem [`CID_FILE_DEPTH];

   // write, then registered read
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule // cid_file_mem

// >>> rtl/cid_decode.sv
/*
 decodes and executes a subset of the 14-bit instruction set: standby entry,
 direction load, pointer add, indirect moves and AND/add with accumulator.
 assumes program memory presents one instruction word with insn_valid and
 takes it when insn_ready is high; the indirect data space answers reads
 combinationally on ind_rd_data.
*/
// Functional notes
// RULE_01: standby opcode one cycle, updates standby flags
// RULE_02: direction load copies accumulator, no flags
// RULE_03: pointer add decodes pointer select, literal
// RULE_04: literal sign-extended, added to pointer pair
// RULE_05: pointer arithmetic wraps modulo sixteen bits
// RULE_06: indirect read with inc/dec, sets zero
// RULE_07: indexed indirect read into accumulator, zero
// RULE_08: indirect write with inc/dec, no flags
// RULE_09: indexed indirect write of accumulator, no flags
// RULE_10: taken branch or counter change adds idle; code adds none for a word that completes from the stall state
// RULE_11: pointer msb set adds one stall cycle
// RULE_12: literal AND into accumulator, zero only
// RULE_13: literal add updates carry, half, zero
// RULE_14: register AND, destination bit, zero only
// RULE_15: register add, destination bit, all three flags
// RULE_16: zero flag set when result is zero
`timescale 1ns/1ps
`include "cid_params.svh"

module cid_decode
   import cid_pkg::*;
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset,
   // instruction stream
   input  wire logic [`CID_INSN_W-1:0]     insn,
   input  wire logic                       insn_valid,
   output logic                            insn_ready,
   // program flow events from the rest of the core
   input  wire logic                       pc_modified,
   input  wire logic                       cond_true,
   // indirect data space
   output logic      [`CID_PTR_W-1:0]      ind_addr,
   output logic                            ind_wr,
   output logic      [`CID_DATA_W-1:0]     ind_wr_data,
   input  wire logic [`CID_DATA_W-1:0]     ind_rd_data,
   // direction load
   output logic                            pin_direction_load,
   output logic      [2:0]                 dir_select,
   output logic      [`CID_DATA_W-1:0]     dir_data,
   // state
   output logic      [`CID_DATA_W-1:0]     acc,
   output logic      [`CID_PTR_W-1:0]      pointer_pair0,
   output logic      [`CID_PTR_W-1:0]      pointer_pair1,
   output logic                            zero_flag,
   output logic                            overflow_out_bit,
   output logic                            half_nibble_overflow,
   output logic                            watchdog_expired_flag,
   output logic                            power_down_flag,
   output logic                            standby_req,
   output logic                            idle_slot
);
   import cid_pkg::*;

   cid_state_t state;
   cid_state_t next_state;

   // add with carry outputs, used by both add forms
   function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      return {s[8], h[4], s[7:0]};
   endfunction

   // pointer plus sign-extended six-bit literal, wraps at sixteen bits
   function automatic logic [15:0] ptr_add(input logic [15:0] p, input logic [5:0] k);
      return p + {{10{k[5]}}, k}; // RULE_04 RULE_05
   endfunction

   // instruction fields
   logic [5:0] top;
   logic       sel_idx;
   logic       sel_ind;
   logic [1:0] mm;
   logic [7:0] lit;
   logic [6:0] faddr;
   logic       dest;
   assign top     = insn[13:8];
   assign sel_idx = insn[`CID_BIT_PTR_IDX];
   assign sel_ind = insn[`CID_BIT_PTR_IND];
   assign mm      = insn[1:0];
   assign lit     = insn[7:0];
   assign faddr   = insn[6:0];
   assign dest    = insn[`CID_BIT_DEST];

   // opcode decode
   logic is_standby, is_dir, is_ptradd, is_ind, is_idx, is_andl, is_addl, is_andf, is_addf;
   logic is_wr;
   assign is_standby = (insn == `CID_OP_STANDBY); // RULE_01
   assign is_dir     = ((insn & `CID_OP_DIRMASK) == `CID_OP_DIRLOAD) && !is_standby; // RULE_02
   assign is_ptradd  = (top == `CID_TOP_PTRADD) && !insn[`CID_BIT_WRITE]; // RULE_03
   assign is_ind     = ((insn & `CID_OP_IND_MASK) == `CID_OP_IND); // RULE_06 RULE_08
   assign is_idx     = (top == `CID_TOP_IDX); // RULE_07 RULE_09
   assign is_andl    = (top == `CID_TOP_ANDLIT);
   assign is_addl    = (top == `CID_TOP_ADDLIT);
   assign is_andf    = (top == `CID_TOP_ANDREG);
   assign is_addf    = (top == `CID_TOP_ADDREG);
   assign is_wr      = is_ind ? insn[3] : insn[`CID_BIT_WRITE];

   // selected pointer and effective address
   logic       psel;
   logic [15:0] pcur, pinc, pdec, pnew, eaddr;
   assign psel  = is_idx ? sel_idx : sel_ind;
   assign pcur  = psel ? pointer_pair1 : pointer_pair0;
   assign pinc  = pcur + 16'h0001; // RULE_05
   assign pdec  = pcur - 16'h0001; // RULE_05
   always_comb begin
      pnew  = pcur;
      eaddr = pcur;
      if (is_idx) begin
         eaddr = ptr_add(pcur, insn[5:0]); // RULE_07 RULE_09
      end else begin
         unique case (mm)
            `CID_MM_PREINC:  begin pnew = pinc; eaddr = pinc; end
            `CID_MM_PREDEC:  begin pnew = pdec; eaddr = pdec; end
            `CID_MM_POSTINC: begin pnew = pinc; eaddr = pcur; end
            `CID_MM_POSTDEC: begin pnew = pdec; eaddr = pcur; end
         endcase
      end
   end

   logic ind_op;
   logic execute;
   assign ind_op  = is_ind || is_idx;
   assign execute = (state == CID_EXEC) && insn_valid;

   // indirect op with pointer msb set waits one cycle before completing
   logic need_stall;
   assign need_stall = ind_op && pcur[15] && (state == CID_EXEC); // RULE_11
   // register forms wait until the registered read shows this word's address
   // and no write landed at the last edge, else the operand would be stale
   logic [6:0] rd_addr_q;
   logic       f_wr_q;
   logic       f_ready;
   assign f_ready = (rd_addr_q == faddr) && !f_wr_q; // RULE_14 RULE_15
   logic commit;
   assign commit = ((execute && !need_stall) || (state == CID_STALL)) && (!(is_andf || is_addf) || f_ready);

   // held instruction is the same word; program memory keeps it while not ready
   assign insn_ready = commit;
   assign idle_slot  = (state == CID_IDLE); // RULE_10

   // state machine
   always_comb begin
      next_state = state;
      unique case (state)
         CID_EXEC: begin
            if (execute && need_stall) begin
               next_state = CID_STALL; // RULE_11
            end else if (commit && (pc_modified || cond_true)) begin
               next_state = CID_IDLE; // RULE_10
            end
         end
         CID_STALL: begin
            next_state = CID_EXEC;
         end
         CID_IDLE: begin
            next_state = CID_EXEC;
         end
         default: begin
            next_state = CID_EXEC;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= CID_EXEC;
      end else begin
         state <= next_state;
      end
   end

   // file register memory
   logic [7:0] fdata;
   logic [7:0] alu_res;
   logic       f_wr;
   assign f_wr = commit && (is_andf || is_addf) && dest; // RULE_14 RULE_15
   cid_file_mem u_mem (
      .clk     (clk),
      .rd_addr (faddr),
      .rd_data (fdata),
      .wr_en   (f_wr),
      .wr_addr (faddr),
      .wr_data (alu_res)
   );

   // address of the read now on fdata, and whether a write may have made it stale
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_addr_q <= 7'h00;
         f_wr_q    <= 1'b0;
      end else begin
         rd_addr_q <= faddr;
         f_wr_q    <= f_wr;
      end
   end

   // alu result and flags
   logic [9:0] sum;
   logic [7:0] operand;
   assign operand = (is_addl || is_andl) ? lit : fdata;
   assign sum     = add8(acc, operand);
   always_comb begin
      alu_res = 8'h00;
      if (is_andl || is_andf) begin
         alu_res = acc & operand; // RULE_12 RULE_14
      end else if (is_addl || is_addf) begin
         alu_res = sum[7:0]; // RULE_13 RULE_15
      end
   end

   logic do_op;
   assign do_op = commit && (!(is_andf || is_addf) || f_ready);

   // accumulator
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         acc <= `CID_ACC_RESET;
      end else if (do_op) begin
         if (is_andl || is_addl || ((is_andf || is_addf) && !dest)) begin
            acc <= alu_res; // RULE_12 RULE_13 RULE_14 RULE_15
         end else if (ind_op && !is_wr) begin
            acc <= ind_rd_data; // RULE_06 RULE_07
         end
      end
   end

   // status flags
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         zero_flag            <= 1'b0;
         overflow_out_bit     <= 1'b0;
         half_nibble_overflow <= 1'b0;
      end else if (do_op) begin
         if (is_andl || is_andf || is_addl || is_addf) begin
            zero_flag <= (alu_res == 8'h00); // RULE_16
         end else if (ind_op && !is_wr) begin
            zero_flag <= (ind_rd_data == 8'h00); // RULE_06 RULE_07 RULE_16
         end
         if (is_addl || is_addf) begin
            overflow_out_bit     <= sum[9]; // RULE_13 RULE_15
            half_nibble_overflow <= sum[8];
         end
      end
   end

   // standby flags: watchdog-expired set, power-down cleared on entry
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         watchdog_expired_flag <= 1'b1;
         power_down_flag       <= 1'b1;
         standby_req           <= 1'b0;
      end else begin
         standby_req <= commit && is_standby; // RULE_01
         if (commit && is_standby) begin
            watchdog_expired_flag <= 1'b1; // RULE_01
            power_down_flag       <= 1'b0;
         end
      end
   end

   // pointer pairs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pointer_pair0 <= `CID_PTR_RESET;
         pointer_pair1 <= `CID_PTR_RESET;
      end else if (commit) begin
         if (is_ptradd) begin
            if (sel_idx) begin
               pointer_pair1 <= ptr_add(pointer_pair1, insn[5:0]); // RULE_03 RULE_04
            end else begin
               pointer_pair0 <= ptr_add(pointer_pair0, insn[5:0]); // RULE_03 RULE_04
            end
         end else if (is_ind) begin
            if (psel) begin
               pointer_pair1 <= pnew; // RULE_06 RULE_08
            end else begin
               pointer_pair0 <= pnew;
            end
         end
      end
   end

   // indirect access and direction load outputs
   assign ind_addr    = eaddr;
   assign ind_wr      = commit && ind_op && is_wr; // RULE_08 RULE_09
   // straight from the accumulator flops, so a write right after an update stores the new value
   assign ind_wr_data = acc; // RULE_08 RULE_09
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_direction_load <= 1'b0;
         dir_select         <= 3'h0;
         dir_data           <= 8'h00;
      end else begin
         pin_direction_load <= commit && is_dir; // RULE_02
         if (commit && is_dir) begin
            dir_select <= insn[2:0];
            dir_data   <= acc;
         end
      end
   end
endmodule // cid_decode

// >>> test/cid_decode_checker.sv
/*
 port checker of the instruction decoder.
 assumes cid_params.svh and a single clock with active high async reset.
*/
`timescale 1ns/1ps
`include "cid_params.svh"

module cid_decode_checker (
   // clock and reset
   input wire logic        clk, reset,
   // instruction stream and flow events
   input wire logic [13:0] insn,
   input wire logic        insn_valid, insn_ready, pc_modified, cond_true,
   // indirect and direction outputs
   input wire logic        ind_wr, pin_direction_load,
   input wire logic [7:0]  ind_rd_data, dir_data,
   input wire logic [2:0]  dir_select,
   // state
   input wire logic [7:0]  acc,
   input wire logic [15:0] pointer_pair0, pointer_pair1,
   input wire logic        zero_flag, overflow_out_bit, half_nibble_overflow,
   input wire logic        watchdog_expired_flag, power_down_flag, standby_req, idle_slot
);
   // a word is taken at this edge
   wire       take = insn_valid && insn_ready;
   wire [5:0] top  = insn[13:8];
   logic [13:0] insn_q;
   logic [7:0]  acc_q, rd_q;
   logic        rdy_q;

   // copies of the values seen at the taking edge
   always_ff @(posedge clk) begin
      insn_q <= insn;
      acc_q  <= acc;
      rd_q   <= ind_rd_data;
      rdy_q  <= insn_ready;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   standby_flags_a: assert property (
      take && insn == `CID_OP_STANDBY |=> watchdog_expired_flag && !power_down_flag && standby_req)
      else $error("standby flags wrong");
   dir_load_a: assert property (
      take && (insn & `CID_OP_DIRMASK) == `CID_OP_DIRLOAD && insn != `CID_OP_STANDBY
      |=> pin_direction_load && dir_data == acc_q && dir_select == insn_q[2:0])
      else $error("direction load wrong");
   ptr_add_a: assert property (
      take && top == `CID_TOP_PTRADD && insn[7:6] == 2'h0
      |=> pointer_pair0 == $past(pointer_pair0) + {{10{insn_q[5]}}, insn_q[5:0]} && $stable(zero_flag))
      else $error("pointer add wrong");
   and_lit_a: assert property (
      take && top == `CID_TOP_ANDLIT
      |=> acc == (acc_q & insn_q[7:0]) && zero_flag == (acc == 8'h00) && $stable(overflow_out_bit))
      else $error("literal and wrong");
   add_lit_a: assert property (
      take && top == `CID_TOP_ADDLIT |=> {overflow_out_bit, acc} == {1'b0, acc_q} + insn_q[7:0]
      && half_nibble_overflow == (acc[4] ^ acc_q[4] ^ insn_q[4]))
      else $error("literal add wrong");
   ind_read_a: assert property (
      take && (insn & `CID_OP_IND_MASK) == `CID_OP_IND && !insn[3]
      |=> acc == rd_q && zero_flag == (acc == 8'h00))
      else $error("indirect read wrong");
   ind_write_a: assert property (
      take && (insn & `CID_OP_IND_MASK) == `CID_OP_IND && insn[3] |-> ind_wr ##1 $stable(zero_flag))
      else $error("indirect write wrong");
   idx_strobe_a: assert property (
      take && top == `CID_TOP_IDX |-> ind_wr == insn[7])
      else $error("indexed strobe wrong");
   idle_cycle_a: assert property (
      take && (pc_modified || cond_true) |=> idle_slot && !insn_ready)
      else $error("idle slot missing");
   high_stall_a: assert property (
      take && top == `CID_TOP_IDX && (insn[6] ? pointer_pair1[15] : pointer_pair0[15]) |-> !rdy_q)
      else $error("stall missing");
endmodule // cid_decode_checker

bind cid_decode cid_decode_checker u_chk (.clk(clk), .reset(reset), .insn(insn), .insn_valid(insn_valid),
   .insn_ready(insn_ready), .pc_modified(pc_modified), .cond_true(cond_true), .ind_wr(ind_wr),
   .pin_direction_load(pin_direction_load), .ind_rd_data(ind_rd_data), .dir_data(dir_data),
   .dir_select(dir_select), .acc(acc), .pointer_pair0(pointer_pair0), .pointer_pair1(pointer_pair1),
   .zero_flag(zero_flag), .overflow_out_bit(overflow_out_bit), .half_nibble_overflow(half_nibble_overflow),
   .watchdog_expired_flag(watchdog_expired_flag), .power_down_flag(power_down_flag),
   .standby_req(standby_req), .idle_slot(idle_slot));

// >>> test/cid_ind_space.sv
/*
 indirect data space model: answers reads at once, takes writes at the edge.
 assumes one clock; unwritten bytes hold a pattern of the address.
*/
`timescale 1ns/1ps

module cid_ind_space (
   // clock
   input  wire logic        clk,
   // access
   input  wire logic [15:0] ind_addr,
   input  wire logic        ind_wr,
   input  wire logic [7:0]  ind_wr_data,
   output logic      [7:0]  ind_rd_data
);
   logic [7:0] mem [0:65535];

   // inverted low address byte, zero only where that byte is FF, so a missed read shows
   initial for (int i = 0; i < 65536; i++) mem[i] = ~i[7:0];
   // write strobe lands on the edge
   always @(posedge clk) if (ind_wr) mem[ind_addr] <= ind_wr_data;
   assign ind_rd_data = mem[ind_addr];
endmodule // cid_ind_space

// >>> test/tb_top.sv
/*
 testbench of the instruction decoder with the indirect space model.
 assumes cid_params.svh; inputs change at the falling edge.
*/
`timescale 1ns/1ps
`include "cid_params.svh"

module tb_top;
   logic        clk = 0, reset = 1, insn_valid = 0, pc_modified = 0, cond_true = 0;
   logic [13:0] insn = 14'h0000;
   wire         insn_ready, ind_wr, pin_direction_load, zero_flag, overflow_out_bit, half_nibble_overflow;
   wire         watchdog_expired_flag, power_down_flag, standby_req, idle_slot;
   wire  [15:0] ind_addr, pointer_pair0, pointer_pair1;
   wire  [7:0]  ind_wr_data, ind_rd_data, dir_data, acc;
   wire  [2:0]  dir_select;
   int          err_total = 0, num_checks = 0, stalls;
   // word, acc, {carry, half carry, zero}
   logic [24:0] rows [7] = '{{14'h3E0F, 8'h0F, 3'b000}, {14'h3E01, 8'h10, 3'b010}, {14'h3EF0, 8'h00, 3'b101},
      {14'h39FF, 8'h00, 3'b101}, {14'h3EFF, 8'hFF, 3'b000}, {14'h393C, 8'h3C, 3'b000}, {14'h39C3, 8'h00, 3'b001}};

   always #5 clk = ~clk;

   cid_decode u_dut (.clk(clk), .reset(reset), .insn(insn), .insn_valid(insn_valid), .insn_ready(insn_ready),
      .pc_modified(pc_modified), .cond_true(cond_true), .ind_addr(ind_addr), .ind_wr(ind_wr),
      .ind_wr_data(ind_wr_data), .ind_rd_data(ind_rd_data), .pin_direction_load(pin_direction_load),
      .dir_select(dir_select), .dir_data(dir_data), .acc(acc), .pointer_pair0(pointer_pair0),
      .pointer_pair1(pointer_pair1), .zero_flag(zero_flag), .overflow_out_bit(overflow_out_bit),
      .half_nibble_overflow(half_nibble_overflow), .watchdog_expired_flag(watchdog_expired_flag),
      .power_down_flag(power_down_flag), .standby_req(standby_req), .idle_slot(idle_slot));
   cid_ind_space u_ind (.clk(clk), .ind_addr(ind_addr), .ind_wr(ind_wr), .ind_wr_data(ind_wr_data),
      .ind_rd_data(ind_rd_data));

   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         err_total++;
      end
   endtask

   // word shown a cycle early (register forms need it), then offered until taken
   task run(input logic [13:0] w, input logic pcm = 1'b0, input logic ct = 1'b0);
      insn = w;
      @(negedge clk);
      insn_valid = 1;
      pc_modified = pcm;
      cond_true = ct;
      stalls = 0;
      #1;
      while (insn_ready !== 1'b1 && stalls < 8) begin
         @(negedge clk);
         #1;
         stalls++;
      end
      if (stalls == 8) chk("ready", 16'h0001, 16'h0000);
      @(negedge clk);
      insn_valid = 0;
      pc_modified = 0;
      cond_true = 0;
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // cut a hang short well past the expected run
   initial begin
      #20000;
      err_total++;
      final_report();
   end

   initial begin
      repeat (12) @(negedge clk);
      reset = 0;
      chk("reset state", 16'h0003, 16'({acc, zero_flag, overflow_out_bit, half_nibble_overflow,
         watchdog_expired_flag, power_down_flag}));
      $display("test reset done");
      foreach (rows[i]) begin
         run(rows[i][24:11]);
         chk("acc", {8'h00, rows[i][10:3]}, {8'h00, acc});
         chk("flags", {13'h0, rows[i][2:0]}, {13'h0, overflow_out_bit, half_nibble_overflow, zero_flag});
      end
      $display("test literal table done");
      run(`CID_OP_STANDBY);
      chk("standby", 16'h0005, 16'({watchdog_expired_flag, power_down_flag, standby_req}));
      run(14'h3E5A);
      run(14'h0065);
      chk("direction", 16'h0D5A, 16'({pin_direction_load, dir_select, dir_data}));
      $display("test standby and direction done");
      run(14'h3120);
      chk("p0", 16'hFFE0, pointer_pair0);
      run(14'h315F);
      chk("p1", 16'h001F, pointer_pair1);
      run(14'h311F);
      run(14'h3101);
      chk("p0", 16'h0000, pointer_pair0);
      $display("test pointer add done");
      run(14'h001E);
      chk("mem", 16'h005A, 16'(u_ind.mem[16'h001F]));
      chk("addr", 16'h0020, ind_addr);
      chk("wdata", 16'h005A, 16'(ind_wr_data));
      chk("p1", 16'h0020, pointer_pair1);
      run(14'h3900);
      run(14'h0015);
      chk("acc", 16'h005A, 16'(acc));
      chk("p1", 16'h001F, pointer_pair1);
      run(14'h3120);
      run(14'h3F85);
      chk("stall", 16'h0001, 16'(stalls));
      chk("mem", 16'h005A, 16'(u_ind.mem[16'hFFE5]));
      run(14'h3900);
      run(14'h3F05);
      chk("acc", 16'h005A, 16'(acc));
      chk("stall", 16'h0001, 16'(stalls));
      $display("test indirect moves done");
      run(14'h3900);
      run(14'h05FF);
      run(14'h3E88);
      run(14'h07FF);
      chk("acc", 16'h0088, 16'(acc));
      run(14'h077F);
      chk("add reg", 16'h0086, 16'({acc, overflow_out_bit, half_nibble_overflow, zero_flag}));
      run(14'h057F);
      chk("and reg", 16'h0007, 16'({acc, overflow_out_bit, half_nibble_overflow, zero_flag}));
      $display("test register ops done");
      run(14'h3E01, 1'b1, 1'b0);
      chk("idle", 16'h0001, 16'(idle_slot));
      run(14'h3E01, 1'b0, 1'b1);
      chk("idle", 16'h0001, 16'(idle_slot));
      run(14'h3E01);
      chk("idle", 16'h0000, 16'(idle_slot));
      reset = 1;
      @(negedge clk);
      chk("second reset", 16'h0000, {acc, pointer_pair0[7:0]});
      reset = 0;
      $display("test idle and reset done");
      final_report();
   end
endmodule // tb_top
